//--- hw/stio_defs.vh
`ifndef STIO_DEFS_VH
`define STIO_DEFS_VH
`define STIO_CLK_HZ 50000000
`define STIO_BAUD_DFLT 9600
`define STIO_DIV_DFLT (`STIO_CLK_HZ / `STIO_BAUD_DFLT)
`define STIO_PMAX_HZ 25000
`define STIO_PMIN_MHZ 200
`define STIO_Q_MIN ((`STIO_CLK_HZ + 4 * `STIO_PMAX_HZ - 1) / (4 * `STIO_PMAX_HZ))
`define STIO_Q_MAX ((`STIO_CLK_HZ / (4 * `STIO_PMIN_MHZ)) * 1000)
`define STIO_Q_RST 26'h00001f4
`define STIO_A_CTRL 8'h00
`define STIO_A_IOCFG 8'h04
`define STIO_A_P1CFG 8'h08
`define STIO_A_P2CFG 8'h0c
`define STIO_A_P1DATA 8'h10
`define STIO_A_P2DATA 8'h14
`define STIO_A_PULSE 8'h18
`define STIO_A_STAT 8'h1c
`define STIO_XON 8'h11
`define STIO_XOFF 8'h13
`define STIO_EOM 8'h0d
`define STIO_C_STBY 0
`define STIO_C_FATAL 1
`define STIO_C_MOVE 2
`define STIO_C_QUAL 3
`define STIO_C_MINR 4
`define STIO_C_ECC 5
`define STIO_C_PRUN 6
`define STIO_C_SWDIR 7
`define STIO_I_DPOL 0
`define STIO_I_INTDIR 1
`define STIO_I_TLB 4
`define STIO_I_AVG 5
`define STIO_I_P1SEL 6
`define STIO_P_FLOW 18
`define STIO_P_HD 18
`define STIO_P_AEN 19
`define STIO_P1_RST 19'h41458
`define STIO_P2_RST 20'h01458
`define STIO_S_OVR1 1
`define STIO_S_OVR2 5
`define STIO_S_ERR1 8
`define STIO_S_ERR2 9
`endif

//--- hw/stio_top.v
// Overview of operation
// - serial port transmit and receive paths work independently and at once.
// - only data lines exist; flow control travels in-band as characters.
// - full receiver sends XOFF; XOFF received halts further transmit data.
// - receiver ready again sends XON; XON received resumes transmit data.
// - characters carry eight data bits and one stop bit.
// - port 1 baud divisor, flow control and parity are software settable.
// - port 1 resets to 9600 baud, no parity, XON/XOFF.
// - shared line: one talker at a time, release line when idle.
// - port 2 runs half duplex only when its half duplex flag is set.
// - multi-drop messages carry an address; only own address is answered.
// - fatal error drives the error output and disables measuring together.
// - phase A and B are equal frequency squares, quarter period apart.
// - pulse frequency is clamped between 0.2 Hz and 25 kHz.
// - valid output follows moving object with good signal by default.
// - valid condition can instead include minimum rate or ECC supervision.
// - high standby input enters standby, same as software standby.
// - direction input active level is configurable and sets direction.
// - light barrier mode uses direction as stop, trigger as start barrier.
// - trigger starts and stops integration on high, low or edge.
// - port 1 data output can be gated by the trigger.
// - averaging mode uses trigger as synchronisation pulse.
// - valid output only while object moves and signal quality is good.
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`include "stio_defs.vh"

// ****************************************
// serial character engine
// ****************************************
module stio_uart (
  // clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // settings
  input wire [15:0] div_in,
  input wire [1:0] parity_in,
  // transmit
  input wire tx_start_in,
  input wire [7:0] tx_data_in,
  output reg txd_out,
  output wire tx_busy_out,
  // receive
  input wire rxd_in,
  input wire rx_en_in,
  output reg rx_valid_out,
  output reg [7:0] rx_data_out,
  output reg rx_err_out
);
  reg [10:0] tx_sh;
  reg [3:0] tx_left;
  reg [15:0] tx_cnt;
  reg [10:0] rx_sh;
  reg [3:0] rx_left;
  reg [15:0] rx_cnt;
  wire par_on = (parity_in != 2'b00);
  wire [3:0] nbits = par_on ? 4'd11 : 4'd10;
  wire [10:0] nsh = {rxd_in, rx_sh[10:1]};
  wire [7:0] rdat = par_on ? nsh[8:1] : nsh[9:2];

  function par_bit;
    input [7:0] d;
    input [1:0] m;
    begin
      par_bit = (m == 2'd2) ? ~^d : ^d;
    end
  endfunction

  assign tx_busy_out = (tx_left != 4'd0);

  // transmit shifter, lsb first
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_sh <= 11'h7ff;
      tx_left <= 4'd0;
      tx_cnt <= 16'h0000;
      txd_out <= 1'b1;
    end else begin
      txd_out <= tx_busy_out ? tx_sh[0] : 1'b1;
      if (!tx_busy_out) begin
        if (tx_start_in) begin
          // start, 8 data, optional parity, 1 stop
          tx_sh <= par_on ? {1'b1, par_bit(tx_data_in, parity_in), tx_data_in, 1'b0}
                          : {2'b11, tx_data_in, 1'b0};
          tx_left <= nbits;
          tx_cnt <= 16'h0000;
        end
      end else if (tx_cnt == div_in - 16'h0001) begin
        tx_cnt <= 16'h0000;
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'd1;
      end else begin
        tx_cnt <= tx_cnt + 16'h0001;
      end
    end
  end

  // receive sampler, mid bit
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_sh <= 11'h000;
      rx_left <= 4'd0;
      rx_cnt <= 16'h0000;
      rx_valid_out <= 1'b0;
      rx_data_out <= 8'h00;
      rx_err_out <= 1'b0;
    end else begin
      rx_valid_out <= 1'b0;
      rx_err_out <= 1'b0;
      if (rx_left == 4'd0) begin
        if (rx_en_in && !rxd_in) begin
          rx_left <= nbits;
          rx_cnt <= {1'b0, div_in[15:1]};
        end
      end else if (rx_cnt == 16'h0000) begin
        rx_cnt <= div_in - 16'h0001;
        rx_sh <= nsh;
        if (rx_left == nbits && rxd_in) begin
          rx_left <= 4'd0;
        end else begin
          rx_left <= rx_left - 4'd1;
        end
        if (rx_left == 4'd1) begin
          rx_data_out <= rdat;
          rx_valid_out <= nsh[10] & (!par_on | (nsh[9] == par_bit(rdat, parity_in)));
          rx_err_out <= !nsh[10] | (par_on & (nsh[9] != par_bit(rdat, parity_in)));
        end
      end else begin
        rx_cnt <= rx_cnt - 16'h0001;
      end
    end
  end
endmodule

// ****************************************
// terminal i/o top
// ****************************************
module stio_top #(
  parameter [25:0] PULSE_QMIN = `STIO_Q_MIN,
  parameter [25:0] PULSE_QMAX = `STIO_Q_MAX
) (
  // clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // ahb-lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  // serial port 1
  input wire port1_rxd_in,
  output wire port1_txd_out,
  // serial port 2
  input wire port2_rxd_in,
  output wire port2_txd_out,
  output wire port2_txd_oe_n_out,
  // plant outputs
  output reg fatal_error_output_out,
  output reg pulse_phase_a_output_out,
  output reg pulse_phase_b_output_out,
  output reg measurement_valid_output_out,
  // plant inputs
  input wire standby_input_in,
  input wire direction_input_in,
  input wire trigger_input_in,
  // internal status
  output reg standby_active_out,
  output reg direction_fwd_out,
  output reg integrate_active_out,
  output reg avg_sync_out
);
  reg [7:0] ctrl;
  reg [9:0] iocfg;
  reg [18:0] p1cfg;
  reg [19:0] p2cfg;
  reg [7:0] p2_station;
  reg [25:0] pulse_q;
  reg wr_ph;
  reg [7:0] wr_addr;
  reg [31:0] rd_mux;
  reg [4:0] sy1;
  reg [4:0] sy2;
  reg [1:0] sy3;
  reg [7:0] tx1_data;
  reg tx1_pend;
  reg halted;
  reg xoff_req;
  reg xon_req;
  reg [7:0] rx1_data;
  reg rx1_full;
  reg [7:0] tx2_data;
  reg tx2_pend;
  reg [7:0] rx2_data;
  reg rx2_full;
  reg addr_wait;
  reg addr_match;
  reg [9:0] stat_st;
  reg [25:0] q_cnt;
  reg [1:0] q_ph;
  reg [25:0] q_eff;
  reg integ;
  wire tx1_busy;
  wire tx2_busy;
  wire rx1_v;
  wire rx1_e;
  wire [7:0] rx1_d;
  wire rx2_v;
  wire rx2_e;
  wire [7:0] rx2_d;

  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  function wr_hit;
    input ph;
    input [7:0] a;
    input [7:0] b;
    begin
      wr_hit = ph & (a == b);
    end
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  wire ahb_go = hsel_in & htrans_in[1] & hready_in;
  wire rd_go = ahb_go & !hwrite_in;
  wire pop1 = rd_go & (haddr_in[7:0] == `STIO_A_P1DATA);
  wire pop2 = rd_go & (haddr_in[7:0] == `STIO_A_P2DATA);
  wire wr_p1d = wr_hit(wr_ph, wr_addr, `STIO_A_P1DATA);
  wire wr_p2d = wr_hit(wr_ph, wr_addr, `STIO_A_P2DATA);
  wire wr_st = wr_hit(wr_ph, wr_addr, `STIO_A_STAT);
  wire flow = p1cfg[`STIO_P_FLOW];
  wire half_dup = p2cfg[`STIO_P_HD];
  wire meas_en = !ctrl[`STIO_C_FATAL] & !standby_active_out;
  wire [13:0] stat_w = {measurement_valid_output_out, integrate_active_out,
                        direction_fwd_out, standby_active_out, stat_st};

  always @* begin
    case (haddr_in[7:0])
      `STIO_A_CTRL: rd_mux = {24'h000000, ctrl};
      `STIO_A_IOCFG: rd_mux = {22'h000000, iocfg};
      `STIO_A_P1CFG: rd_mux = {13'h0000, p1cfg};
      `STIO_A_P2CFG: rd_mux = {p2_station, 4'h0, p2cfg};
      `STIO_A_P1DATA: rd_mux = {23'h000000, rx1_full, rx1_data};
      `STIO_A_P2DATA: rd_mux = {23'h000000, rx2_full, rx2_data};
      `STIO_A_PULSE: rd_mux = {6'h00, pulse_q};
      `STIO_A_STAT: rd_mux = {18'h00000, stat_w};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ph <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h00000000;
      ctrl <= 8'h00;
      iocfg <= 10'h000;
      p1cfg <= `STIO_P1_RST;
      p2cfg <= `STIO_P2_RST;
      p2_station <= 8'h00;
      pulse_q <= `STIO_Q_RST;
    end else begin
      wr_ph <= ahb_go & hwrite_in;
      if (ahb_go) begin
        wr_addr <= haddr_in[7:0];
      end
      if (rd_go) begin
        hrdata_out <= rd_mux;
      end
      if (wr_hit(wr_ph, wr_addr, `STIO_A_CTRL)) begin
        ctrl <= hwdata_in[7:0];
      end
      if (wr_hit(wr_ph, wr_addr, `STIO_A_IOCFG)) begin
        iocfg <= hwdata_in[9:0];
      end
      if (wr_hit(wr_ph, wr_addr, `STIO_A_P1CFG)) begin
        p1cfg <= hwdata_in[18:0];
      end
      if (wr_hit(wr_ph, wr_addr, `STIO_A_P2CFG)) begin
        p2cfg <= hwdata_in[19:0];
        p2_station <= hwdata_in[31:24];
      end
      if (wr_hit(wr_ph, wr_addr, `STIO_A_PULSE)) begin
        pulse_q <= hwdata_in[25:0];
      end
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sy1 <= 5'h18;
      sy2 <= 5'h18;
      sy3 <= 2'b00;
    end else begin
      sy1 <= {port2_rxd_in, port1_rxd_in, trigger_input_in,
              direction_input_in, standby_input_in};
      sy2 <= sy1;
      sy3 <= sy2[2:1];
    end
  end
  wire dir_rise = sy2[1] & !sy3[0];
  wire trig_rise = sy2[2] & !sy3[1];

  // ****************************************
  // port 1 with in-band flow control
  // ****************************************
  wire gate1 = !iocfg[`STIO_I_P1SEL] | integrate_active_out;
  wire go_x = xoff_req | xon_req;
  wire go_d = tx1_pend & !halted & gate1;
  wire start1 = !tx1_busy & (go_x | go_d);
  wire [7:0] src1 = xoff_req ? `STIO_XOFF : xon_req ? `STIO_XON : tx1_data;
  wire is_xoff = flow & (rx1_d == `STIO_XOFF);
  wire is_xon = flow & (rx1_d == `STIO_XON);
  wire store1 = rx1_v & !is_xoff & !is_xon;

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx1_data <= 8'h00;
      tx1_pend <= 1'b0;
      halted <= 1'b0;
      xoff_req <= 1'b0;
      xon_req <= 1'b0;
      rx1_data <= 8'h00;
      rx1_full <= 1'b0;
    end else begin
      if (wr_p1d && !tx1_pend) begin
        tx1_data <= hwdata_in[7:0];
      end
      if (start1 && !go_x) begin
        tx1_pend <= 1'b0;
      end else if (wr_p1d) begin
        tx1_pend <= 1'b1;
      end
      if (!flow || (rx1_v && is_xon)) begin
        halted <= 1'b0;
      end else if (rx1_v && is_xoff) begin
        halted <= 1'b1;
      end
      if (flow && store1) begin
        xoff_req <= 1'b1;
        xon_req <= 1'b0;
      end else if (flow && pop1 && rx1_full) begin
        xon_req <= 1'b1;
        xoff_req <= 1'b0;
      end else if (start1) begin
        xoff_req <= 1'b0;
        if (!xoff_req) begin
          xon_req <= 1'b0;
        end
      end
      if (store1) begin
        rx1_data <= rx1_d;
      end
      rx1_full <= store1 | (rx1_full & !pop1);
    end
  end

  stio_uart u_port1 (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .div_in(p1cfg[15:0]),
    .parity_in(p1cfg[17:16]),
    .tx_start_in(start1),
    .tx_data_in(src1),
    .txd_out(port1_txd_out),
    .tx_busy_out(tx1_busy),
    .rxd_in(sy2[3]),
    .rx_en_in(1'b1),
    .rx_valid_out(rx1_v),
    .rx_data_out(rx1_d),
    .rx_err_out(rx1_e)
  );

  // ****************************************
  // port 2, optional multi-drop
  // ****************************************
  wire start2 = !tx2_busy & tx2_pend;
  wire addr_on = p2cfg[`STIO_P_AEN];
  wire take2 = rx2_v & (!addr_on | (!addr_wait & addr_match));
  assign port2_txd_oe_n_out = half_dup ? !tx2_busy : 1'b0;

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx2_data <= 8'h00;
      tx2_pend <= 1'b0;
      rx2_data <= 8'h00;
      rx2_full <= 1'b0;
      addr_wait <= 1'b1;
      addr_match <= 1'b0;
    end else begin
      if (wr_p2d && !tx2_pend) begin
        tx2_data <= hwdata_in[7:0];
      end
      tx2_pend <= (tx2_pend & !start2) | wr_p2d;
      if (!addr_on) begin
        addr_wait <= 1'b1;
      end else if (rx2_v && addr_wait) begin
        addr_match <= (rx2_d == p2_station);
        addr_wait <= 1'b0;
      end else if (rx2_v && rx2_d == `STIO_EOM) begin
        addr_wait <= 1'b1;
      end
      if (take2) begin
        rx2_data <= rx2_d;
      end
      rx2_full <= take2 | (rx2_full & !pop2);
    end
  end

  stio_uart u_port2 (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .div_in(p2cfg[15:0]),
    .parity_in(p2cfg[17:16]),
    .tx_start_in(start2),
    .tx_data_in(tx2_data),
    .txd_out(port2_txd_out),
    .tx_busy_out(tx2_busy),
    .rxd_in(sy2[4]),
    .rx_en_in(!(half_dup & tx2_busy)),
    .rx_valid_out(rx2_v),
    .rx_data_out(rx2_d),
    .rx_err_out(rx2_e)
  );

  // live and sticky status; on sticky bits set wins over write-one clear
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat_st <= 10'h000;
    end else begin
      stat_st[0] <= rx1_full;
      stat_st[2] <= tx1_pend;
      stat_st[3] <= halted;
      stat_st[4] <= rx2_full;
      stat_st[6] <= tx2_pend;
      stat_st[7] <= fatal_error_output_out;
      stat_st[`STIO_S_OVR1] <= (store1 & rx1_full & !pop1)
                             | (stat_st[`STIO_S_OVR1] & !(wr_st & hwdata_in[`STIO_S_OVR1]));
      stat_st[`STIO_S_OVR2] <= (take2 & rx2_full & !pop2)
                             | (stat_st[`STIO_S_OVR2] & !(wr_st & hwdata_in[`STIO_S_OVR2]));
      stat_st[`STIO_S_ERR1] <= rx1_e
                             | (stat_st[`STIO_S_ERR1] & !(wr_st & hwdata_in[`STIO_S_ERR1]));
      stat_st[`STIO_S_ERR2] <= rx2_e
                             | (stat_st[`STIO_S_ERR2] & !(wr_st & hwdata_in[`STIO_S_ERR2]));
    end
  end

  // ****************************************
  // plant inputs and outputs
  // ****************************************
  wire lb_mode = iocfg[`STIO_I_TLB];
  wire avg_mode = iocfg[`STIO_I_AVG];
  wire [1:0] tmode = iocfg[3:2];
  wire [1:0] vsrc = iocfg[9:8];
  wire use_sw_dir = iocfg[`STIO_I_INTDIR] | lb_mode;
  wire dir_pin = iocfg[`STIO_I_DPOL] ? sy2[1] : !sy2[1];
  wire next_fwd = use_sw_dir ? ctrl[`STIO_C_SWDIR] : dir_pin;
  wire cond = (vsrc == 2'd1) ? ctrl[`STIO_C_MINR] :
              (vsrc == 2'd2) ? ctrl[`STIO_C_ECC] : 1'b1;
  wire next_valid = meas_en & ctrl[`STIO_C_MOVE] & ctrl[`STIO_C_QUAL] & cond;

  always @* begin
    if (PULSE_QMIN > pulse_q) begin
      q_eff = PULSE_QMIN;
    end else if (pulse_q > PULSE_QMAX) begin
      q_eff = PULSE_QMAX;
    end else begin
      q_eff = pulse_q;
    end
  end

  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      integ <= 1'b0;
      q_cnt <= 26'h0000000;
      q_ph <= 2'b00;
      fatal_error_output_out <= 1'b0;
      pulse_phase_a_output_out <= 1'b0;
      pulse_phase_b_output_out <= 1'b0;
      measurement_valid_output_out <= 1'b0;
      standby_active_out <= 1'b0;
      direction_fwd_out <= 1'b1;
      integrate_active_out <= 1'b0;
      avg_sync_out <= 1'b0;
    end else begin
      fatal_error_output_out <= ctrl[`STIO_C_FATAL];
      standby_active_out <= sy2[0] | ctrl[`STIO_C_STBY];
      direction_fwd_out <= next_fwd;
      measurement_valid_output_out <= next_valid;
      avg_sync_out <= avg_mode & trig_rise;
      if (!meas_en || avg_mode) begin
        integ <= 1'b0;
      end else if (lb_mode) begin
        if (trig_rise) begin
          integ <= 1'b1;
        end else if (dir_rise) begin
          integ <= 1'b0;
        end
      end else if (tmode == 2'd0) begin
        integ <= sy2[2];
      end else if (tmode == 2'd1) begin
        integ <= !sy2[2];
      end else if (trig_rise) begin
        integ <= !integ;
      end
      integrate_active_out <= integ;
      // quadrature stepper, gray order
      if (!(ctrl[`STIO_C_PRUN] & meas_en)) begin
        q_cnt <= 26'h0000000;
      end else if (q_cnt >= q_eff - 26'h0000001) begin
        q_cnt <= 26'h0000000;
        q_ph <= direction_fwd_out ? q_ph + 2'b01 : q_ph - 2'b01;
      end else begin
        q_cnt <= q_cnt + 26'h0000001;
      end
      pulse_phase_a_output_out <= q_ph[1] ^ q_ph[0];
      pulse_phase_b_output_out <= q_ph[1];
    end
  end
endmodule

//--- hw/stio_top_dummy_never.v
`include "stio_defs.vh"

//--- testbench/stio_chk.sv
// ********
// port checks
// ********
module stio_chk (
  // clock and reset
  input wire sys_clk_in,
  input wire resetn_in,
  // watched pins
  input wire port1_txd_out,
  input wire port2_txd_out,
  input wire port2_txd_oe_n_out,
  input wire fatal_error_output_out,
  input wire pulse_phase_a_output_out,
  input wire pulse_phase_b_output_out,
  input wire measurement_valid_output_out,
  input wire standby_input_in,
  input wire standby_active_out,
  input wire avg_sync_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);
  property p_fatal_valid;
    fatal_error_output_out [*2] |-> !measurement_valid_output_out;
  endproperty
  a_fatal_valid: assert property (p_fatal_valid) else $error("valid in fatal");
  property p_fatal_stop;
    fatal_error_output_out [*3] |->
      $stable(pulse_phase_a_output_out) && $stable(pulse_phase_b_output_out);
  endproperty
  a_fatal_stop: assert property (p_fatal_stop) else $error("pulses in fatal");
  property p_quad;
    !($changed(pulse_phase_a_output_out) && $changed(pulse_phase_b_output_out));
  endproperty
  a_quad: assert property (p_quad) else $error("both phases moved");
  property p_stby;
    standby_input_in [*4] |-> standby_active_out;
  endproperty
  a_stby: assert property (p_stby) else $error("standby missed");
  property p_stby_valid;
    standby_active_out [*3] |-> !measurement_valid_output_out;
  endproperty
  a_stby_valid: assert property (p_stby_valid) else $error("valid in standby");
  property p_release;
    $changed(port2_txd_out) |-> !port2_txd_oe_n_out;
  endproperty
  a_release: assert property (p_release) else $error("sent undriven");
  property p_start;
    $fell(port1_txd_out) |-> !port1_txd_out [*8];
  endproperty
  a_start: assert property (p_start) else $error("short start bit");
  property p_avg;
    avg_sync_out |=> !avg_sync_out;
  endproperty
  a_avg: assert property (p_avg) else $error("long sync pulse");
endmodule

//--- testbench/stio_host.sv
// ********
// host serial end
// ********
module stio_host #(
  parameter int DIV = 16
) (
  // link
  input wire clk_in,
  input wire rxd_in,
  output logic txd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [7:0] r;
  logic halted = 1'b0;
  initial txd_out = 1'b1;
  // flow characters go out even while halted
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (halted && b != 8'h11 && b != 8'h13) @(posedge clk_in);
    for (int i = 0; i < 10; i++) begin
      txd_out <= f[i];
      repeat (DIV) @(posedge clk_in);
    end
  endtask
  // receiver runs beside the sender
  initial forever begin
    @(negedge rxd_in);
    repeat (DIV / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV) @(posedge clk_in);
      r[i] = rxd_in;
    end
    repeat (DIV) @(posedge clk_in);
    if (r == 8'h13) halted = 1'b1;
    if (r == 8'h11) halted = 1'b0;
    got.push_back(r);
  end
endmodule

//--- testbench/stio_top_test.sv
// ********
// bench top
// ********
module stio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, resetn_in, hsel_in, hwrite_in;
  logic standby_input_in, direction_input_in, trigger_input_in;
  logic [31:0] haddr_in, hwdata_in, v;
  logic [1:0] htrans_in;
  logic [2:0] hsize_in;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, port1_rxd_in, port1_txd_out, port2_rxd_in, port2_txd_out;
  wire port2_txd_oe_n_out, fatal_error_output_out, pulse_phase_a_output_out;
  wire pulse_phase_b_output_out, measurement_valid_output_out, standby_active_out;
  wire direction_fwd_out, integrate_active_out, avg_sync_out;
  int failures, tests_run;
  stio_top #(.PULSE_QMIN(26'd4), .PULSE_QMAX(26'd40)) stio_top_inst (
    .hready_in(hreadyout_out),
    .*
  );
  stio_host stio_host_inst (.clk_in(sys_clk_in), .rxd_in(port1_txd_out), .txd_out(port1_rxd_in));
  stio_host stio_host_inst_p2 (
    .clk_in(sys_clk_in),
    .rxd_in(port2_txd_out),
    .txd_out(port2_rxd_in)
  );
  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= w;
    haddr_in <= {24'h0, a};
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge sys_clk_in); while (hreadyout_out !== 1'b1);
    r = hrdata_out;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, v);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    ahb(1'b0, a, 32'h0, v);
    chk(v & m, e);
  endtask
  task automatic rx(input bit p2, input logic [7:0] e);
    while ((p2 ? stio_host_inst_p2.got.size() : stio_host_inst.got.size()) == 0) cyc(1);
    if (p2) chk(stio_host_inst_p2.got.pop_front(), e);
    else chk(stio_host_inst.got.pop_front(), e);
  endtask
  task automatic set(input logic [7:0] a, input logic [31:0] d, input logic e);
    wr(a, d);
    cyc(6);
    chk(measurement_valid_output_out, e);
  endtask
  // plant levels change only here, one clean step each, rates scaled down
  task automatic pins(input logic s, input logic d, input logic t);
    standby_input_in <= s;
    direction_input_in <= d;
    trigger_input_in <= t;
  endtask
  // quarter period from leading rise to trailing rise
  task automatic lag(input int q, input logic fwd);
    int n;
    n = 0;
    cyc(200);
    wait ({pulse_phase_a_output_out, pulse_phase_b_output_out} == 2'b00);
    wait ({pulse_phase_a_output_out, pulse_phase_b_output_out} != 2'b00);
    chk({pulse_phase_a_output_out, pulse_phase_b_output_out}, {fwd, !fwd});
    while ({pulse_phase_a_output_out, pulse_phase_b_output_out} != 2'b11) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk(n, q);
    cyc(1);
  endtask
  task automatic t_serial;
    rc(8'h08, 32'h40000 | 50000000 / 9600);
    rc(8'h20, 32'h0);
    wr(8'h08, 32'h40010);
    stio_host_inst.send(8'h33);
    rx(0, 8'h13);
    rc(8'h10, 32'h133);
    rx(0, 8'h11);
    fork
      wr(8'h10, 32'h5a);
      stio_host_inst.send(8'h44);
    join
    rx(0, 8'h5a);
    rx(0, 8'h13);
    rc(8'h10, 32'h144);
    rx(0, 8'h11);
    stio_host_inst.send(8'h13);
    wr(8'h10, 32'h77);
    cyc(400);
    chk(stio_host_inst.got.size(), 0);
    rc(8'h1c, 32'hc, 32'hc);
    stio_host_inst.send(8'h11);
    rx(0, 8'h77);
    wr(8'h04, 32'h40);
    wr(8'h10, 32'h66);
    cyc(400);
    chk(stio_host_inst.got.size(), 0);
    pins(1'b0, 1'b1, 1'b1);
    rx(0, 8'h66);
    pins(1'b0, 1'b1, 1'b0);
    wr(8'h04, 32'h0);
  endtask
  task automatic t_port2;
    chk(port2_txd_oe_n_out, 0);
    wr(8'h0c, 32'h40010);
    wr(8'h14, 32'ha5);
    cyc(20);
    chk(port2_txd_oe_n_out, 0);
    rx(1, 8'ha5);
    cyc(20);
    chk(port2_txd_oe_n_out, 1);
    wr(8'h0c, 32'h42080010);
    stio_host_inst_p2.send(8'h42);
    stio_host_inst_p2.send(8'h99);
    rc(8'h14, 32'h199);
    stio_host_inst_p2.send(8'h0d);
    stio_host_inst_p2.send(8'h41);
    stio_host_inst_p2.send(8'h98);
    rc(8'h14, 32'h10d);
    rc(8'h14, 32'h0, 32'h100);
  endtask
  task automatic t_plant;
    set(8'h00, 32'h0c, 1);
    set(8'h00, 32'h04, 0);
    set(8'h00, 32'h0c, 1);
    set(8'h04, 32'h100, 0);
    set(8'h00, 32'h1c, 1);
    set(8'h04, 32'h200, 0);
    set(8'h00, 32'h2c, 1);
    pins(1'b1, 1'b1, 1'b0);
    cyc(6);
    chk(standby_active_out, 1);
    rc(8'h1c, 32'h400, 32'h2400);
    pins(1'b0, 1'b1, 1'b0);
    set(8'h00, 32'h2d, 0);
    chk(standby_active_out, 1);
    set(8'h00, 32'h2e, 0);
    chk(fatal_error_output_out, 1);
  endtask
  task automatic t_pulse;
    wr(8'h04, 32'h1);
    wr(8'h18, 32'h8);
    wr(8'h00, 32'h40);
    lag(8, 1);
    pins(1'b0, 1'b0, 1'b0);
    lag(8, 0);
    chk(direction_fwd_out, 0);
    wr(8'h04, 32'h0);
    lag(8, 1);
    wr(8'h18, 32'h1);
    lag(4, 1);
    wr(8'h18, 32'h3e8);
    lag(40, 1);
  endtask
  task automatic t_trig;
    int n;
    n = 0;
    pins(1'b0, 1'b0, 1'b1);
    cyc(6);
    chk(integrate_active_out, 1);
    wr(8'h04, 32'h4);
    cyc(6);
    chk(integrate_active_out, 0);
    wr(8'h04, 32'h8);
    for (int k = 1; k >= 0; k--) begin
      pins(1'b0, 1'b0, 1'b0);
      cyc(6);
      pins(1'b0, 1'b0, 1'b1);
      cyc(6);
      chk(integrate_active_out, k);
    end
    wr(8'h04, 32'h10);
    pins(1'b0, 1'b0, 1'b0);
    cyc(6);
    pins(1'b0, 1'b0, 1'b1);
    cyc(6);
    chk(integrate_active_out, 1);
    pins(1'b0, 1'b1, 1'b1);
    cyc(6);
    chk(integrate_active_out, 0);
    wr(8'h04, 32'h20);
    pins(1'b0, 1'b1, 1'b0);
    cyc(6);
    pins(1'b0, 1'b1, 1'b1);
    repeat (10) begin
      cyc(1);
      n += avg_sync_out;
    end
    chk(n, 1);
  endtask
  initial begin
    resetn_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    standby_input_in = 1'b0;
    direction_input_in = 1'b1;
    trigger_input_in = 1'b0;
    failures = 0;
    tests_run = 0;
    cyc(5);
    resetn_in <= 1'b1;
    cyc(1);
    t_serial;
    t_port2;
    t_plant;
    t_pulse;
    t_trig;
    wrap_up;
  end
  initial begin
    cyc(60000);
    failures++;
    wrap_up;
  end
endmodule
bind stio_top stio_chk stio_chk_inst (.*);
